// ==== siopcn_pkg.sv ====
// Constants shared by the shared I/O port with change notification.
// Assumes a 32-bit AHB-Lite register bus and word-aligned registers.
package siopcn_pkg;

    // Bus and port sizes
    localparam int unsigned SIOPCN_BUS_W = 32;
    localparam int unsigned SIOPCN_ADDR_W = 8;
    localparam int unsigned SIOPCN_PORT_W = 16;
    localparam int unsigned SIOPCN_CN_W = 31;
    localparam int unsigned SIOPCN_CN_LOW_W = 16;
    localparam int unsigned SIOPCN_MAX_PORT_W = 16;
    localparam int unsigned SIOPCN_MAX_CN_W = 31;

    // Register byte offsets
    localparam logic [7:0] SIOPCN_OFF_DIR = 8'h00;
    localparam logic [7:0] SIOPCN_OFF_LATCH = 8'h04;
    localparam logic [7:0] SIOPCN_OFF_LEVEL = 8'h08;
    localparam logic [7:0] SIOPCN_OFF_ODC = 8'h0c;
    localparam logic [7:0] SIOPCN_OFF_APC = 8'h10;
    localparam logic [7:0] SIOPCN_OFF_CNEN_LO = 8'h14;
    localparam logic [7:0] SIOPCN_OFF_CNEN_HI = 8'h18;
    localparam logic [7:0] SIOPCN_OFF_PU_LO = 8'h1c;
    localparam logic [7:0] SIOPCN_OFF_PU_HI = 8'h20;
    localparam logic [7:0] SIOPCN_OFF_CN_STAT = 8'h24;

    // Reset values
    localparam logic [31:0] SIOPCN_RST_ZERO = 32'h0000_0000;
    localparam logic [15:0] SIOPCN_APC_RESET = 16'h0000;
    localparam logic [15:0] SIOPCN_IMPL_DEFAULT = 16'hffff;
    localparam logic [15:0] SIOPCN_ANALOG_DEFAULT = 16'h003f;

    // AHB-Lite codes
    localparam logic [1:0] SIOPCN_HRESP_OKAY = 2'h0;
    localparam int unsigned SIOPCN_HTRANS_ACTIVE_BIT = 1;

endpackage

// ==== siopcn_sync.sv ====
// Two-flop synchroniser for a vector of asynchronous levels.
// Assumes each bit is an independent level; no bus coherency.
`timescale 1ns/1ps

module siopcn_sync #(
    parameter int unsigned WIDTH = 16
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_reg;

    // First stage is read only by the second
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage1_reg <= '0;
            sync_out <= '0;
        end else begin
            stage1_reg <= async_in;
            sync_out <= stage1_reg;
        end
    end

endmodule

// ==== siopcn_top.sv ====
// Shared parallel I/O port with open drain, analog select and
// input change notification, reached over AHB-Lite.
// Assumes a single AHB-Lite master, word transfers only, and that
// hclk keeps running while the core sleeps.
`timescale 1ns/1ps

module siopcn_top
    import siopcn_pkg::*;
#(
    parameter int unsigned PORT_W = siopcn_pkg::SIOPCN_PORT_W,
    parameter int unsigned CN_W = siopcn_pkg::SIOPCN_CN_W,
    parameter logic [15:0] IMPL_MASK = siopcn_pkg::SIOPCN_IMPL_DEFAULT,
    parameter logic [15:0] ANALOG_MASK = siopcn_pkg::SIOPCN_ANALOG_DEFAULT
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Port pins
    input wire logic [PORT_W-1:0] pad_in,
    output logic [PORT_W-1:0] pad_out,
    output logic [PORT_W-1:0] pad_oe,
    // Peripherals sharing the pins
    input wire logic [PORT_W-1:0] periph_out_en,
    input wire logic [PORT_W-1:0] periph_out_data,
    output logic [PORT_W-1:0] periph_in_data,
    // Change notification pins
    input wire logic [CN_W-1:0] change_notify_pin,
    output logic [CN_W-1:0] cn_pullup_en,
    output logic cn_irq_req
);
    import siopcn_pkg::*;

    localparam int unsigned CN_HI_W = CN_W - SIOPCN_CN_LOW_W;

    generate
        if (PORT_W > SIOPCN_MAX_PORT_W || PORT_W == 0) begin : g_bad_port
            $error("siopcn_top: PORT_W out of range");
        end
        if (CN_W > SIOPCN_MAX_CN_W || CN_W <= SIOPCN_CN_LOW_W) begin : g_bad_cn
            $error("siopcn_top: CN_W out of range");
        end
    endgenerate

    localparam logic [PORT_W-1:0] IMPL = IMPL_MASK[PORT_W-1:0];
    localparam logic [PORT_W-1:0] ANA = ANALOG_MASK[PORT_W-1:0];

    // Bus data phase state
    logic dp_active_reg;
    logic dp_write_reg;
    logic [SIOPCN_ADDR_W-1:0] dp_addr_reg;
    logic [31:0] hrdata_reg;
    logic hreadyout_reg;

    // Software visible registers
    logic [PORT_W-1:0] pin_direction_reg;
    logic [PORT_W-1:0] output_latch_reg;
    logic [PORT_W-1:0] open_drain_ctrl_reg;
    logic [PORT_W-1:0] analog_pin_config_reg;
    logic [SIOPCN_CN_LOW_W-1:0] change_irq_enable_low;
    logic [CN_HI_W-1:0] change_irq_enable_high;
    logic [SIOPCN_CN_LOW_W-1:0] pullup_enable_low;
    logic [CN_HI_W-1:0] pullup_enable_high;
    logic [CN_W-1:0] cn_pending_reg;
    logic [CN_W-1:0] cn_pending_next;

    // Pin side state
    logic [PORT_W-1:0] pad_sync;
    logic [CN_W-1:0] cn_sync;
    logic [CN_W-1:0] cn_prev_reg;
    logic [PORT_W-1:0] pad_out_reg;
    logic [PORT_W-1:0] pad_oe_reg;
    logic [PORT_W-1:0] periph_in_reg;
    logic [CN_W-1:0] cn_pullup_reg;
    logic cn_irq_reg;

    // Decoded and derived terms
    logic addr_accept;
    logic wr_en;
    logic rd_en;
    logic [31:0] rd_mux;
    logic [PORT_W-1:0] pin_level_reg;
    logic [PORT_W-1:0] analog_eff;
    logic [PORT_W-1:0] periph_owns;
    logic [PORT_W-1:0] port_drives;
    logic [PORT_W-1:0] drive_data;
    logic [PORT_W-1:0] drive_on;
    logic [CN_W-1:0] cn_enable_all;
    logic [CN_W-1:0] cn_change;

    siopcn_sync #(
        .WIDTH(PORT_W)
    ) u_pad_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(pad_in),
        .sync_out(pad_sync)
    );

    siopcn_sync #(
        .WIDTH(CN_W)
    ) u_cn_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(change_notify_pin),
        .sync_out(cn_sync)
    );

    assign addr_accept = hsel && htrans[SIOPCN_HTRANS_ACTIVE_BIT] && hready;
    assign wr_en = dp_active_reg && dp_write_reg;
    assign rd_en = dp_active_reg && !dp_write_reg;

    // One wait state so read data leaves a flip-flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_active_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_addr_reg <= '0;
            hreadyout_reg <= 1'b1;
        end else if (addr_accept) begin
            dp_active_reg <= 1'b1;
            dp_write_reg <= hwrite;
            dp_addr_reg <= haddr[SIOPCN_ADDR_W-1:0];
            hreadyout_reg <= 1'b0;
        end else begin
            dp_active_reg <= 1'b0;
            hreadyout_reg <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= SIOPCN_RST_ZERO;
        end else if (rd_en) begin
            hrdata_reg <= rd_mux;
        end
    end

    // Analog pins have a clear config bit
    assign analog_eff = ~analog_pin_config_reg & ANA;

    assign pin_level_reg = pad_sync & ~analog_eff & IMPL;

    always_comb begin
        rd_mux = SIOPCN_RST_ZERO;
        unique case (dp_addr_reg)
            SIOPCN_OFF_DIR: begin
                rd_mux[PORT_W-1:0] = pin_direction_reg & IMPL;
            end
            SIOPCN_OFF_LATCH: begin
                rd_mux[PORT_W-1:0] = output_latch_reg & IMPL;
            end
            SIOPCN_OFF_LEVEL: begin
                rd_mux[PORT_W-1:0] = pin_level_reg;
            end
            SIOPCN_OFF_ODC: begin
                rd_mux[PORT_W-1:0] = open_drain_ctrl_reg;
            end
            SIOPCN_OFF_APC: begin
                rd_mux[PORT_W-1:0] = analog_pin_config_reg;
            end
            SIOPCN_OFF_CNEN_LO: begin
                rd_mux[SIOPCN_CN_LOW_W-1:0] = change_irq_enable_low;
            end
            SIOPCN_OFF_CNEN_HI: begin
                rd_mux[CN_HI_W-1:0] = change_irq_enable_high;
            end
            SIOPCN_OFF_PU_LO: begin
                rd_mux[SIOPCN_CN_LOW_W-1:0] = pullup_enable_low;
            end
            SIOPCN_OFF_PU_HI: begin
                rd_mux[CN_HI_W-1:0] = pullup_enable_high;
            end
            SIOPCN_OFF_CN_STAT: begin
                rd_mux[CN_W-1:0] = cn_pending_reg;
            end
            default: begin
                rd_mux = SIOPCN_RST_ZERO;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_direction_reg <= IMPL;
        end else if (wr_en && dp_addr_reg == SIOPCN_OFF_DIR) begin
            pin_direction_reg <= hwdata[PORT_W-1:0] & IMPL;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            output_latch_reg <= SIOPCN_RST_ZERO[PORT_W-1:0];
        end else if (wr_en && (dp_addr_reg == SIOPCN_OFF_LATCH
                || dp_addr_reg == SIOPCN_OFF_LEVEL)) begin
            output_latch_reg <= hwdata[PORT_W-1:0] & IMPL;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            open_drain_ctrl_reg <= SIOPCN_RST_ZERO[PORT_W-1:0];
        end else if (wr_en && dp_addr_reg == SIOPCN_OFF_ODC) begin
            open_drain_ctrl_reg <= hwdata[PORT_W-1:0] & IMPL;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            analog_pin_config_reg <= SIOPCN_APC_RESET[PORT_W-1:0];
        end else if (wr_en && dp_addr_reg == SIOPCN_OFF_APC) begin
            analog_pin_config_reg <= hwdata[PORT_W-1:0] & ANA;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            change_irq_enable_low <= '0;
            change_irq_enable_high <= '0;
        end else if (wr_en && dp_addr_reg == SIOPCN_OFF_CNEN_LO) begin
            change_irq_enable_low <= hwdata[SIOPCN_CN_LOW_W-1:0];
        end else if (wr_en && dp_addr_reg == SIOPCN_OFF_CNEN_HI) begin
            change_irq_enable_high <= hwdata[CN_HI_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pullup_enable_low <= '0;
            pullup_enable_high <= '0;
        end else if (wr_en && dp_addr_reg == SIOPCN_OFF_PU_LO) begin
            pullup_enable_low <= hwdata[SIOPCN_CN_LOW_W-1:0];
        end else if (wr_en && dp_addr_reg == SIOPCN_OFF_PU_HI) begin
            pullup_enable_high <= hwdata[CN_HI_W-1:0];
        end
    end

    assign periph_owns = periph_out_en & IMPL;
    assign port_drives = ~periph_owns & ~pin_direction_reg & IMPL;
    assign drive_data = (periph_owns & periph_out_data)
        | (~periph_owns & output_latch_reg);
    assign drive_on = periph_owns | port_drives;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pad_oe_reg <= SIOPCN_RST_ZERO[PORT_W-1:0];
            pad_out_reg <= SIOPCN_RST_ZERO[PORT_W-1:0];
        end else begin
            pad_oe_reg <= drive_on & (~open_drain_ctrl_reg | ~drive_data);
            pad_out_reg <= drive_data & ~open_drain_ctrl_reg & IMPL;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            periph_in_reg <= SIOPCN_RST_ZERO[PORT_W-1:0];
        end else begin
            periph_in_reg <= pad_sync & ~port_drives & IMPL;
        end
    end

    assign cn_enable_all = {change_irq_enable_high, change_irq_enable_low};

    assign cn_change = (cn_sync ^ cn_prev_reg) & cn_enable_all;

    // Previous sample tracks even disabled pins, so enabling is clean
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cn_prev_reg <= '0;
        end else begin
            cn_prev_reg <= cn_sync;
        end
    end

    // Write one to clear; a new change wins over the clear
    always_comb begin
        cn_pending_next = cn_pending_reg;
        if (wr_en && dp_addr_reg == SIOPCN_OFF_CN_STAT) begin
            cn_pending_next = cn_pending_next & ~hwdata[CN_W-1:0];
        end
        cn_pending_next = cn_pending_next | cn_change;
    end

    // runs on hclk, not the CPU clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cn_pending_reg <= '0;
        end else begin
            cn_pending_reg <= cn_pending_next;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cn_irq_reg <= 1'b0;
        end else begin
            cn_irq_reg <= |cn_pending_next;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cn_pullup_reg <= '0;
        end else begin
            cn_pullup_reg <= {pullup_enable_high, pullup_enable_low};
        end
    end

    assign hrdata = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp = SIOPCN_HRESP_OKAY[0];
    assign pad_out = pad_out_reg;
    assign pad_oe = pad_oe_reg;
    assign periph_in_data = periph_in_reg;
    assign cn_pullup_en = cn_pullup_reg;
    assign cn_irq_req = cn_irq_reg;

endmodule

// ==== siopcn_properties.sv ====
// Checker for the shared I/O port, bound to siopcn_top ports.
// Assumes one AHB-Lite master with hready fed back from hreadyout.
`timescale 1ns/1ps
module siopcn_properties #(
    parameter int unsigned PORT_W = 16,
    parameter int unsigned CN_W = 31
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Pins and peripherals
    input wire logic [PORT_W-1:0] pad_out,
    input wire logic [PORT_W-1:0] pad_oe,
    input wire logic [PORT_W-1:0] periph_out_en,
    input wire logic [PORT_W-1:0] periph_out_data,
    input wire logic [PORT_W-1:0] periph_in_data,
    input wire logic [CN_W-1:0] change_notify_pin,
    input wire logic [CN_W-1:0] cn_pullup_en,
    input wire logic cn_irq_req
);
    logic wr_taken;
    logic rd_taken;
    assign wr_taken = hsel & htrans[1] & hready & hwrite;
    assign rd_taken = hsel & htrans[1] & hready & ~hwrite;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_req;
        hsel && htrans[1] && hready;
    endsequence
    sequence s_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    a_ready_one_wait: assert property (s_req |=> s_wait)
        else $error("bus answer not after one wait");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    a_periph_owns_pin: assert property ((pad_out & $past(periph_out_en)
        & ~$past(periph_out_data)) == '0) else $error("port drove a peripheral pin");
    a_no_loop_through: assert property ((periph_in_data & pad_oe
        & ~$past(periph_out_en)) == '0) else $error("port output reached peripheral");
    a_irq_after_change: assert property ($rose(cn_irq_req) |->
        $past(change_notify_pin, 2) != $past(change_notify_pin, 5))
        else $error("change request without pin change");
    a_irq_clear_write: assert property ($fell(cn_irq_req) |->
        $past(wr_taken, 2) || $past(wr_taken, 3)) else $error("request dropped by itself");
    a_pullup_by_write: assert property ($changed(cn_pullup_en) |->
        $past(wr_taken, 2) || $past(wr_taken, 3)) else $error("pull-up changed unasked");
    a_rdata_by_read: assert property ($changed(hrdata) |-> $past(rd_taken, 2))
        else $error("read data moved without a read");
    a_oe_idle_reset: assert property ($rose(hresetn) |-> pad_oe == '0)
        else $error("pin driven out of reset");
    c_irq: cover property ($rose(cn_irq_req));
endmodule

// ==== siopcn_pin_model.sv ====
// Pins and outside sources facing the port.
// Assumes the bench chooses which lines an outside source holds.
`timescale 1ns/1ps
module siopcn_pin_model #(
    parameter int unsigned PORT_W = 16,
    parameter int unsigned CN_W = 31
) (
    // Clock
    input wire logic hclk,
    // Port side
    input wire logic [PORT_W-1:0] pad_out,
    input wire logic [PORT_W-1:0] pad_oe,
    input wire logic [CN_W-1:0] cn_pullup_en,
    // Outside sources
    input wire logic [PORT_W-1:0] ext_drv,
    input wire logic [PORT_W-1:0] ext_val,
    input wire logic [CN_W-1:0] cn_drv,
    input wire logic [CN_W-1:0] cn_val,
    // Levels seen by the port
    output logic [PORT_W-1:0] pad_in,
    output logic [CN_W-1:0] change_notify_pin
);
    logic float_reg = 1'b0;
    // Undriven lines wander, so a stale level never looks driven
    always @(posedge hclk) float_reg <= ~float_reg;
    // port drive wins, then outside source
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_drv & ext_val)
        | (~pad_oe & ~ext_drv & {PORT_W{float_reg}});
    // weak pull-up holds a released line high
    assign change_notify_pin = (cn_drv & cn_val) | (~cn_drv & cn_pullup_en)
        | (~cn_drv & ~cn_pullup_en & {CN_W{float_reg}});
endmodule

// ==== siopcn_top_tb.sv ====
// Self-checking bench for siopcn_top with the pin model.
// Assumes default widths: 16 port pins, 31 change pins.
`timescale 1ns/1ps
module siopcn_top_tb;
    logic hclk = 1'b0;
    logic hresetn, hsel, hwrite, hreadyout, hresp, cn_irq_req;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [31:0] hrdata_part;
    logic [15:0] pad_in, pad_out, pad_oe, periph_out_en, periph_out_data, periph_in_data;
    logic [15:0] ext_drv, ext_val;
    logic [30:0] change_notify_pin, cn_pullup_en, cn_drv, cn_val;
    int err_total = 0;
    int num_checks = 0;
    int i;
    logic [7:0] t_addr [9] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h28};
    logic [31:0] t_wd [9] = '{32'hffff_a5a5, 32'hffff_5a5a, 32'h0000_00f0, 32'h0000_0015,
        32'hffff_ffff, 32'hffff_ffff, 32'h0000_1234, 32'hffff_ffff, 32'hffff_ffff};
    logic [31:0] t_exp [9] = '{32'h0000_a5a5, 32'h0000_5a5a, 32'h0000_00f0, 32'h0000_0015,
        32'h0000_ffff, 32'h0000_7fff, 32'h0000_1234, 32'h0000_7fff, 32'h0000_0000};
    always #2.5 hclk = ~hclk;
    siopcn_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .periph_out_en(periph_out_en),
        .periph_out_data(periph_out_data), .periph_in_data(periph_in_data),
        .change_notify_pin(change_notify_pin), .cn_pullup_en(cn_pullup_en),
        .cn_irq_req(cn_irq_req));
    siopcn_pin_model i_pins (.hclk(hclk), .pad_out(pad_out), .pad_oe(pad_oe),
        .cn_pullup_en(cn_pullup_en), .ext_drv(ext_drv), .ext_val(ext_val), .cn_drv(cn_drv),
        .cn_val(cn_val), .pad_in(pad_in), .change_notify_pin(change_notify_pin));
    // Second port with the top pin left out, answers in step with i_dut
    siopcn_top #(.IMPL_MASK(16'h7fff)) i_dut_part (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata_part), .hreadyout(), .hresp(),
        .pad_in(pad_in), .pad_out(), .pad_oe(), .periph_out_en(periph_out_en),
        .periph_out_data(periph_out_data), .periph_in_data(),
        .change_notify_pin(change_notify_pin), .cn_pullup_en(), .cn_irq_req());
    task automatic report_and_stop();
        if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Holds each phase until hready is seen high at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge hclk);
        // No cycle count assumed; only the watchdog ends a hang
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0000_0000, x);
        chk(x, e);
    endtask
    // idle before read-back
    // Margin over the sync and output stages before looking at pins
    task automatic settle();
        repeat (6) @(posedge hclk);
    endtask
    initial begin
        repeat (20000) @(posedge hclk);
        err_total++;
        report_and_stop();
    end
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        {periph_out_en, periph_out_data, ext_drv, ext_val} = '0;
        cn_drv = '1;
        cn_val = '0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (i = 0; i < 9; i++) begin
            rd_chk(t_addr[i], (i == 0) ? 32'h0000_ffff : 32'h0000_0000);
            wr(t_addr[i], t_wd[i]);
            rd_chk(t_addr[i], t_exp[i]);
        end
        chk({1'b0, cn_pullup_en}, 32'h7fff_1234);
        ext_drv <= 16'hff00;
        ext_val <= 16'h3c00;
        wr(8'h00, 32'h0000_ff00);
        wr(8'h04, 32'h0000_00a5);
        wr(8'h0c, 32'h0000_0000);
        wr(8'h10, 32'h0000_003f);
        settle();
        chk({16'h0000, pad_oe}, 32'h0000_00ff);
        chk({16'h0000, pad_out & 16'h00ff}, 32'h0000_00a5);
        rd_chk(8'h08, 32'h0000_3ca5);
        rd_chk(8'h04, 32'h0000_00a5);
        wr(8'h00, 32'h0000_ff3f);
        wr(8'h10, 32'h0000_0000);
        rd_chk(8'h08, 32'h0000_3c80);
        wr(8'h08, 32'h0000_0f0f);
        rd_chk(8'h04, 32'h0000_0f0f);
        wr(8'h10, 32'h0000_003f);
        wr(8'h00, 32'h0000_ff00);
        settle();
        bus(1'b0, 8'h08, 32'h0000_0000, r);
        wr(8'h08, r | 32'h0000_0100);
        rd_chk(8'h04, 32'h0000_3d0f);
        periph_out_en <= 16'h0003;
        periph_out_data <= 16'h0001;
        wr(8'h0c, 32'h0000_0010);
        settle();
        chk({16'h0000, pad_oe & 16'h00ff}, 32'h0000_00ff);
        chk({16'h0000, pad_out & 16'h00ff}, 32'h0000_000d);
        chk({16'h0000, periph_in_data}, 32'h0000_3c01);
        wr(8'h04, 32'h0000_3d1f);
        periph_out_en <= 16'h0000;
        settle();
        chk({16'h0000, pad_oe & 16'h00ff}, 32'h0000_00ef);
        chk({16'h0000, pad_out & 16'h00ff}, 32'h0000_000f);
        wr(8'h14, 32'h0000_0001);
        wr(8'h18, 32'h0000_4000);
        wr(8'h24, 32'hffff_ffff);
        cn_val <= 31'h0000_0002;
        settle();
        chk({31'h0, cn_irq_req}, 32'h0000_0000);
        rd_chk(8'h24, 32'h0000_0000);
        cn_val <= 31'h4000_0003;
        settle();
        chk({31'h0, cn_irq_req}, 32'h0000_0001);
        rd_chk(8'h24, 32'h4000_0001);
        wr(8'h24, 32'h0000_0001);
        rd_chk(8'h24, 32'h4000_0000);
        wr(8'h24, 32'h4000_0000);
        chk({31'h0, cn_irq_req}, 32'h0000_0000);
        hresetn <= 1'b0;
        periph_out_en <= 16'h0003;
        repeat (5) @(posedge hclk);
        chk({16'h0000, pad_oe}, 32'h0000_0000);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(8'h00, 32'h0000_ffff);
        chk(hrdata_part, 32'h0000_7fff);
        rd_chk(8'h10, 32'h0000_0000);
        report_and_stop();
    end
endmodule
bind siopcn_top siopcn_properties #(.PORT_W(PORT_W), .CN_W(CN_W)) i_props (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pad_out(pad_out),
    .pad_oe(pad_oe), .periph_out_en(periph_out_en), .periph_out_data(periph_out_data),
    .periph_in_data(periph_in_data), .change_notify_pin(change_notify_pin),
    .cn_pullup_en(cn_pullup_en), .cn_irq_req(cn_irq_req));
